/* File: ddrb_pkg.sv */
package ddrb_pkg;

	// ----------------------------------------------------------
	// Clocking and timing
	// ----------------------------------------------------------
	localparam int PCLK_PS = 10000;
	localparam int CK_HALF = 4;
	localparam int CK_PS = 2 * CK_HALF * PCLK_PS;
	localparam int TWR_PS = 15000;
	localparam int TWTR_PS = 7500;
	localparam int TRCD_PS = 15000;
	localparam int STROBE_LAG = 2;

	function automatic int ck_min(input int ps);
		int n;
		n = (ps + CK_PS - 1) / CK_PS;
		return (n < 1) ? 1 : n;
	endfunction

	localparam int TWR_CK = ck_min(TWR_PS);
	localparam int TWTR_CK = ck_min(TWTR_PS);
	localparam int TRCD_CK = ck_min(TRCD_PS);

	// ----------------------------------------------------------
	// Link geometry
	// ----------------------------------------------------------
	localparam int ADDR_W = 14;
	localparam int BA_W = 3;
	localparam int DQ_W = 8;
	localparam int CMD_W = 4 + ADDR_W + BA_W;
	localparam int PIPE_DEPTH = 16;
	localparam int MEM_DEPTH = 64;
	localparam int BURST_W = 64;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;

	// ----------------------------------------------------------
	// Register map
	// ----------------------------------------------------------
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_WDATA_LO = 8'h08;
	localparam logic [7:0] REG_WDATA_HI = 8'h0c;
	localparam logic [7:0] REG_RDATA_LO = 8'h10;
	localparam logic [7:0] REG_RDATA_HI = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam int CFG_BL_LSB = 0;
	localparam int CFG_INTLV_BIT = 3;
	localparam int CFG_CL_LSB = 4;
	localparam int CFG_AL_LSB = 8;
	localparam int CFG_EARLY_BIT = 12;
	localparam logic [31:0] CFG_RESET = 32'h0000_0032;
	localparam int CMD_COL_LSB = 0;
	localparam int CMD_BA_LSB = 10;
	localparam int CMD_WR_BIT = 16;

	// ----------------------------------------------------------
	// Shared decoding
	// ----------------------------------------------------------
	function automatic logic [2:0] burst_col(input logic [2:0] st, input logic [2:0] bt,
		input logic intlv);
		logic [1:0] lo;
		lo = intlv ? (st[1:0] ^ bt[1:0]) : (st[1:0] + bt[1:0]);
		return {st[2] ^ bt[2], lo};
	endfunction

	function automatic logic [4:0] read_lat(input logic [2:0] cl, input logic [2:0] al);
		return {2'h0, cl} + {2'h0, al};
	endfunction

	function automatic logic is_bl8(input logic [2:0] code);
		return code == BL_CODE_8;
	endfunction

	function automatic logic [2:0] last_beat(input logic bl8);
		return bl8 ? 3'h7 : 3'h3;
	endfunction

endpackage

/* File: ddrb_if.sv */
`timescale 1ns/100ps
interface ddrb_if;
	logic ck;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [13:0] addr;
	logic [2:0] ba;
	logic [7:0] ctl_dq_o;
	logic ctl_dq_oe_n;
	logic ctl_dqs_o;
	logic ctl_dqs_oe_n;
	logic [7:0] dev_dq_o;
	logic dev_dq_oe_n;
	logic dev_dqs_o;
	logic dev_dqs_oe_n;
	logic [7:0] dq;
	logic dqs;

	// ----------------------------------------------------------
	// Wire resolution, idle bus reads low
	// ----------------------------------------------------------
	assign dq = !ctl_dq_oe_n ? ctl_dq_o : (!dev_dq_oe_n ? dev_dq_o : 8'h00);
	assign dqs = !ctl_dqs_oe_n ? ctl_dqs_o : (!dev_dqs_oe_n ? dev_dqs_o : 1'b0);

	modport ctrl(
		output ck, cs_n, ras_n, cas_n, we_n, addr, ba,
		output ctl_dq_o, ctl_dq_oe_n, ctl_dqs_o, ctl_dqs_oe_n,
		input dq, dqs
	);
	modport dev(
		input ck, cs_n, ras_n, cas_n, we_n, addr, ba,
		output dev_dq_o, dev_dq_oe_n, dev_dqs_o, dev_dqs_oe_n,
		input dq, dqs
	);
endinterface

/* File: ddrb_ctrl.sv */
`timescale 1ns/100ps
module ddrb_ctrl
	import ddrb_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Memory link
	ddrb_if.ctrl link
);
	logic [31:0] cfg;
	logic [63:0] wdata, rdata, cur_data, wbuf;
	logic rdone, slot_v, slot_wr, last_wr, wr_act, strobe_hi;
	logic [9:0] slot_col;
	logic [2:0] slot_ba, wr_beat, rd_beat, last;
	logic [1:0] div;
	logic [4:0] gap, need, half, rl;
	logic [3:0] rd_out, recov, wtap, ptap;
	logic [STROBE_LAG-1:0] edge_d;
	logic [PIPE_DEPTH-1:0] pv, pwr;
	logic [63:0] pdat [PIPE_DEPTH];
	logic dqs_s1, dqs_s2, dqs_q;
	logic [7:0] dq_s1, dq_s2;
	logic acc, take, cmd_hit, early_bad, ck_ev, ck_rise, issue, wr_due, pre_due;
	logic dqs_ev, rd_done, busy, rd_arm;
	logic [2:0] cl, al;

	assign cl = cfg[CFG_CL_LSB +: 3];
	assign al = cfg[CFG_AL_LSB +: 3];
	assign rl = read_lat(cl, al);
	assign last = last_beat(is_bl8(cfg[CFG_BL_LSB +: 3]));
	assign half = is_bl8(cfg[CFG_BL_LSB +: 3]) ? 5'd4 : 5'd2;

	// ----------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------
	assign acc = psel & penable & ~pready;
	assign take = psel & penable & pready;
	assign cmd_hit = pwrite & (paddr == REG_CMD);
	assign early_bad = cfg[CFG_EARLY_BIT] & (({2'h0, al} + 5'd1) < 5'(TRCD_CK));
	assign busy = slot_v | ~link.cs_n | (|pv) | wr_act | (rd_out != 4'h0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= acc & ~(cmd_hit & slot_v);
			if (acc) begin
				pslverr <= cmd_hit & early_bad;
				case (paddr)
					REG_CFG: prdata <= cfg;
					REG_CMD: prdata <= 32'h0;
					REG_WDATA_LO: prdata <= wdata[31:0];
					REG_WDATA_HI: prdata <= wdata[63:32];
					REG_RDATA_LO: prdata <= rdata[31:0];
					REG_RDATA_HI: prdata <= rdata[63:32];
					REG_STATUS: prdata <= {29'h0, rdone, (recov == 4'h0) & ~wr_act, busy};
					default: begin
						prdata <= 32'h0;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= CFG_RESET;
			wdata <= 64'h0;
		end else if (take & pwrite & ~pslverr) begin
			if (paddr == REG_CFG)
				cfg <= pwdata;
			if (paddr == REG_WDATA_LO)
				wdata[31:0] <= pwdata;
			if (paddr == REG_WDATA_HI)
				wdata[63:32] <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_v <= 1'b0;
			slot_wr <= 1'b0;
			slot_col <= 10'h0;
			slot_ba <= 3'h0;
		end else if (take & cmd_hit & ~pslverr) begin
			slot_v <= 1'b1;
			slot_wr <= pwdata[CMD_WR_BIT];
			slot_col <= pwdata[CMD_COL_LSB +: 10];
			slot_ba <= pwdata[CMD_BA_LSB +: 3];
		end else if (issue) begin
			slot_v <= 1'b0;
		end
	end

	// ----------------------------------------------------------
	// Link clock divider
	// ----------------------------------------------------------
	assign ck_ev = div == 2'(CK_HALF - 1);
	assign ck_rise = ck_ev & ~link.ck;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div <= 2'h0;
			link.ck <= 1'b0;
		end else begin
			div <= ck_ev ? 2'h0 : div + 2'd1;
			if (ck_ev)
				link.ck <= ~link.ck;
		end
	end

	// ----------------------------------------------------------
	// Command issue and spacing
	// ----------------------------------------------------------
	always_comb begin
		if (slot_wr == last_wr)
			need = half;
		else if (slot_wr)
			need = half + 5'd2;
		else
			need = {2'h0, cl} - 5'd1 + half + 5'(TWTR_CK);
	end
	assign issue = ck_ev & link.ck & slot_v & (gap >= need);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap <= 5'h1f;
			last_wr <= 1'b0;
			cur_data <= 64'h0;
		end else if (issue) begin
			gap <= 5'h0;
			last_wr <= slot_wr;
			cur_data <= wdata;
		end else if (ck_rise & (gap != 5'h1f)) begin
			gap <= gap + 5'd1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.cs_n <= 1'b1;
			link.ras_n <= 1'b1;
			link.cas_n <= 1'b1;
			link.we_n <= 1'b1;
			link.addr <= 14'h0;
			link.ba <= 3'h0;
		end else if (issue) begin
			link.cs_n <= 1'b0;
			link.ras_n <= 1'b1;
			link.cas_n <= 1'b0;
			link.we_n <= ~slot_wr;
			link.addr <= {4'h0, slot_col};
			link.ba <= slot_ba;
		end else if (ck_ev & link.ck) begin
			link.cs_n <= 1'b1;
		end
	end

	// ----------------------------------------------------------
	// Latency pipeline, age counted in link clocks
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pv <= '0;
			pwr <= '0;
			for (int i = 0; i < PIPE_DEPTH; i++)
				pdat[i] <= 64'h0;
		end else if (ck_rise) begin
			pv <= {pv[PIPE_DEPTH-2:0], ~link.cs_n};
			pwr <= {pwr[PIPE_DEPTH-2:0], ~link.we_n};
			pdat[0] <= cur_data;
			for (int i = 1; i < PIPE_DEPTH; i++)
				pdat[i] <= pdat[i-1];
		end
	end

	assign wtap = 4'(rl - 5'd2);
	assign ptap = 4'(rl - 5'd3);
	assign wr_due = pv[wtap] & pwr[wtap];
	assign pre_due = pv[ptap] & pwr[ptap];

	// ----------------------------------------------------------
	// Write data and strobe
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_act <= 1'b0;
			wr_beat <= 3'h0;
			wbuf <= 64'h0;
			strobe_hi <= 1'b0;
			link.ctl_dq_o <= 8'h0;
			link.ctl_dq_oe_n <= 1'b1;
			link.ctl_dqs_oe_n <= 1'b1;
		end else if (ck_rise & wr_due) begin
			wr_act <= 1'b1;
			wr_beat <= 3'h0;
			wbuf <= pdat[wtap];
			link.ctl_dq_o <= pdat[wtap][7:0];
			link.ctl_dq_oe_n <= 1'b0;
			link.ctl_dqs_oe_n <= 1'b0;
			strobe_hi <= 1'b1;
		end else if (ck_ev & wr_act & (wr_beat != last)) begin
			wr_beat <= wr_beat + 3'd1;
			link.ctl_dq_o <= wbuf[{wr_beat + 3'd1, 3'h0} +: 8];
			strobe_hi <= ck_rise;
		end else if (ck_rise) begin
			wr_act <= 1'b0;
			link.ctl_dq_oe_n <= 1'b1;
			link.ctl_dqs_oe_n <= ~pre_due;
			strobe_hi <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_d <= '0;
			link.ctl_dqs_o <= 1'b0;
		end else begin
			edge_d <= {edge_d[STROBE_LAG-2:0], ck_ev};
			if (edge_d[STROBE_LAG-1])
				link.ctl_dqs_o <= strobe_hi;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			recov <= 4'h0;
		else if (ck_rise & wr_act & (wr_beat == last) & ~wr_due)
			recov <= 4'(TWR_CK);
		else if (ck_rise & (recov != 4'h0))
			recov <= recov - 4'd1;
	end

	// ----------------------------------------------------------
	// Read capture
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dqs_s1 <= 1'b0;
			dqs_s2 <= 1'b0;
			dqs_q <= 1'b0;
			dq_s1 <= 8'h0;
			dq_s2 <= 8'h0;
		end else begin
			dqs_s1 <= link.dqs;
			dqs_s2 <= dqs_s1;
			dqs_q <= dqs_s2;
			dq_s1 <= link.dq;
			dq_s2 <= dq_s1;
		end
	end

	assign dqs_ev = (dqs_s2 ^ dqs_q) & (rd_out != 4'h0);
	assign rd_done = dqs_ev & (rd_beat == last);
	// Arm capture at the read preamble, clear of own write strobes
	assign rd_arm = ck_rise & pv[wtap] & ~pwr[wtap];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_beat <= 3'h0;
			rdata <= 64'h0;
			rd_out <= 4'h0;
			rdone <= 1'b0;
		end else begin
			if (dqs_ev) begin
				rdata[{rd_beat, 3'h0} +: 8] <= dq_s2;
				rd_beat <= rd_done ? 3'h0 : rd_beat + 3'd1;
			end
			rd_out <= rd_out + {3'h0, rd_arm} - {3'h0, rd_done};
			if (rd_done)
				rdone <= 1'b1;
			else if (take & ~pwrite & (paddr == REG_RDATA_HI))
				rdone <= 1'b0;
		end
	end

endmodule // ddrb_ctrl

/* File: ddrb_device.sv */
`timescale 1ns/100ps
// Functional notes
// - CS, CAS low, RAS high starts column access
// - Burst four: commands at least two clocks apart
// - Burst eight: commands at least four clocks apart
// - Accept early commands, hold for additive latency
// - Read data after additive plus CAS latency
// - Early commands need nonzero additive latency first; the controller also accepts them at zero additive latency
// - Write latency equals read latency minus one
// - Only burst lengths four and eight
// - Bit three picks sequential or interleaved
// - Sequential order wraps within nibble, then other
// - Interleaved order XORs start with beat
// - Never cut a burst four short
// - No burst stop; bursts run full length
// - Read strobe low one clock before data
// - First read data on first strobe rise
// - Read to write needs half burst plus two
// - Reads every half burst stream without gaps
// - Writes every half burst stream without gaps
// - Controller drives write preamble, data after it
// - Data beyond burst length is ignored
// - Write to read needs CL-1+BL/2+tWTR
// - Write recovery counted from burst end
module ddrb_device
	import ddrb_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Memory link
	ddrb_if.dev link,
	// Mode settings
	input wire logic [2:0] mode_burst,
	input wire logic mode_interleave,
	input wire logic [2:0] mode_cl,
	input wire logic [2:0] mode_al
);
	logic [CMD_W-1:0] cmd_s1, cmd_s2;
	logic ck_s1, ck_s2, ck_q;
	logic dqs_s1, dqs_s2, dqs_q;
	logic [DQ_W-1:0] dq_s1, dq_s2;
	logic s_cs_n, s_ras_n, s_cas_n, s_we_n;
	logic [ADDR_W-1:0] s_addr;
	logic [BA_W-1:0] s_ba;
	logic ck_rise, ck_ev, dqs_ev, col_cmd, bl8;
	logic [2:0] last;
	logic [4:0] rl;
	logic [3:0] rtap, wtap;
	logic read_due, pre_due, wr_due;
	logic [PIPE_DEPTH-1:0] pv, prd;
	logic [5:0] pad [PIPE_DEPTH];
	logic [DQ_W-1:0] mem [MEM_DEPTH];
	logic rd_act, strobe_hi;
	logic [2:0] rd_beat;
	logic [5:0] rd_base;
	logic [STROBE_LAG-1:0] edge_d;
	logic wr_act, wr_nxt_v, wr_end;
	logic [2:0] wr_beat;
	logic [5:0] wr_base, wr_nxt;

	function automatic logic [5:0] mem_idx(input logic [5:0] base, input logic [2:0] beat);
		return {base[5:3], burst_col(base[2:0], beat, mode_interleave)};
	endfunction

	// ----------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_s1 <= '1;
			cmd_s2 <= '1;
			ck_s1 <= 1'b0;
			ck_s2 <= 1'b0;
			ck_q <= 1'b0;
			dqs_s1 <= 1'b0;
			dqs_s2 <= 1'b0;
			dqs_q <= 1'b0;
			dq_s1 <= '0;
			dq_s2 <= '0;
		end else begin
			cmd_s1 <= {link.cs_n, link.ras_n, link.cas_n, link.we_n, link.addr, link.ba};
			cmd_s2 <= cmd_s1;
			ck_s1 <= link.ck;
			ck_s2 <= ck_s1;
			ck_q <= ck_s2;
			dqs_s1 <= link.dqs;
			dqs_s2 <= dqs_s1;
			dqs_q <= dqs_s2;
			dq_s1 <= link.dq;
			dq_s2 <= dq_s1;
		end
	end

	assign {s_cs_n, s_ras_n, s_cas_n, s_we_n, s_addr, s_ba} = cmd_s2;
	assign ck_rise = ck_s2 & ~ck_q;
	assign ck_ev = ck_s2 ^ ck_q;
	assign dqs_ev = dqs_s2 ^ dqs_q;

	// ----------------------------------------------------------
	// Command decode and mode
	// ----------------------------------------------------------
	assign col_cmd = ck_rise & ~s_cs_n & s_ras_n & ~s_cas_n;
	assign bl8 = is_bl8(mode_burst);
	assign last = last_beat(bl8);
	assign rl = read_lat(mode_cl, mode_al);

	// ----------------------------------------------------------
	// Posted command pipeline
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pv <= '0;
			prd <= '0;
			for (int i = 0; i < PIPE_DEPTH; i++)
				pad[i] <= 6'h0;
		end else if (ck_rise) begin
			pv <= {pv[PIPE_DEPTH-2:0], col_cmd};
			prd <= {prd[PIPE_DEPTH-2:0], s_we_n};
			pad[0] <= {s_ba, s_addr[2:0]};
			for (int i = 1; i < PIPE_DEPTH; i++)
				pad[i] <= pad[i-1];
		end
	end

	assign rtap = 4'(rl - 5'd1);
	assign wtap = 4'(rl - 5'd2);
	assign read_due = pv[rtap] & prd[rtap];
	assign pre_due = pv[wtap] & prd[wtap];
	assign wr_due = pv[wtap] & ~prd[wtap];

	// ----------------------------------------------------------
	// Read burst engine
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_act <= 1'b0;
			rd_beat <= 3'h0;
			rd_base <= 6'h0;
			strobe_hi <= 1'b0;
			link.dev_dq_o <= '0;
			link.dev_dq_oe_n <= 1'b1;
			link.dev_dqs_oe_n <= 1'b1;
		end else if (ck_rise & read_due) begin
			rd_act <= 1'b1;
			rd_beat <= 3'h0;
			rd_base <= pad[rtap];
			link.dev_dq_o <= mem[mem_idx(pad[rtap], 3'h0)];
			link.dev_dq_oe_n <= 1'b0;
			link.dev_dqs_oe_n <= 1'b0;
			strobe_hi <= 1'b1;
		end else if (ck_ev & rd_act & (rd_beat != last)) begin
			rd_beat <= rd_beat + 3'd1;
			link.dev_dq_o <= mem[mem_idx(rd_base, rd_beat + 3'd1)];
			strobe_hi <= ck_rise;
		end else if (ck_rise) begin
			rd_act <= 1'b0;
			link.dev_dq_oe_n <= 1'b1;
			link.dev_dqs_oe_n <= ~pre_due;
			strobe_hi <= 1'b0;
		end
	end

	// ----------------------------------------------------------
	// Read strobe, centred after each data change
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_d <= '0;
			link.dev_dqs_o <= 1'b0;
		end else begin
			edge_d <= {edge_d[STROBE_LAG-2:0], ck_ev};
			if (edge_d[STROBE_LAG-1])
				link.dev_dqs_o <= strobe_hi;
		end
	end

	// ----------------------------------------------------------
	// Write burst engine
	// ----------------------------------------------------------
	assign wr_end = dqs_ev & wr_act & (wr_beat == last);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_act <= 1'b0;
			wr_beat <= 3'h0;
			wr_base <= 6'h0;
			wr_nxt_v <= 1'b0;
			wr_nxt <= 6'h0;
		end else begin
			if (dqs_ev & wr_act) begin
				if (wr_beat != last) begin
					wr_beat <= wr_beat + 3'd1;
				end else if (wr_nxt_v) begin
					wr_beat <= 3'h0;
					wr_base <= wr_nxt;
					wr_nxt_v <= 1'b0;
				end else begin
					wr_act <= 1'b0;
				end
			end
			if (ck_rise & wr_due) begin
				if (!wr_act | (wr_end & ~wr_nxt_v)) begin
					wr_act <= 1'b1;
					wr_beat <= 3'h0;
					wr_base <= pad[wtap];
				end else begin
					wr_nxt_v <= 1'b1;
					wr_nxt <= pad[wtap];
				end
			end
		end
	end

	// ----------------------------------------------------------
	// Storage array
	// ----------------------------------------------------------
	always_ff @(posedge pclk) begin
		if (dqs_ev & wr_act)
			mem[mem_idx(wr_base, wr_beat)] <= dq_s2;
	end

endmodule // ddrb_device

/* File: ddrb_assertions.sv */
`timescale 1ns/100ps
module ddrb_assertions
	import ddrb_pkg::*;
(
	// Clock, reset and modes
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] mode_burst,
	input wire logic [2:0] mode_cl,
	input wire logic [2:0] mode_al,
	// Link
	input wire logic ck,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [13:0] addr,
	input wire logic [2:0] ba,
	input wire logic ctl_dqs_o,
	input wire logic ctl_dqs_oe_n,
	input wire logic [7:0] dev_dq_o,
	input wire logic dev_dq_oe_n,
	input wire logic dev_dqs_o,
	input wire logic dev_dqs_oe_n
);
	// ----------------------------------------
	// Command spacing and beat counts
	// ----------------------------------------
	logic ck_q;
	logic last_wr;
	logic cmd;
	int gap;
	int s_rd;
	int s_wr;
	int rd_exp;
	int rd_got;
	int wr_exp;
	int wr_got;
	int half;
	int rl;
	assign cmd = ck && !ck_q && !cs_n && ras_n && !cas_n;
	assign half = (mode_burst == BL_CODE_8) ? 4 : 2;
	assign rl = int'(mode_cl) + int'(mode_al);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_q <= 1'b0;
			last_wr <= 1'b0;
			gap <= 1000;
			s_rd <= 0;
			s_wr <= 0;
			rd_exp <= 0;
			rd_got <= 0;
			wr_exp <= 0;
			wr_got <= 0;
		end else begin
			ck_q <= ck;
			gap <= cmd ? 0 : ((ck && !ck_q && gap < 1000) ? gap + 1 : gap);
			s_rd <= (cmd && we_n) ? 0 : s_rd + 1;
			s_wr <= (cmd && !we_n) ? 0 : s_wr + 1;
			last_wr <= cmd ? !we_n : last_wr;
			rd_exp <= (cmd && we_n) ? rd_exp + half : rd_exp;
			wr_exp <= (cmd && !we_n) ? wr_exp + half : wr_exp;
			rd_got <= (!dev_dqs_oe_n && $rose(dev_dqs_o)) ? rd_got + 1 : rd_got;
			wr_got <= (!ctl_dqs_oe_n && $rose(ctl_dqs_o)) ? wr_got + 1 : wr_got;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_CMD_HOLD: assert property ($rose(ck) |-> $stable({cs_n, ras_n, cas_n, we_n, ba, addr}))
		else $error("command pins moved at link clock rise");
	AST_TCCD: assert property (cmd && (we_n != last_wr) |-> gap + 1 >= half)
		else $error("same-type commands too close");
	AST_RD2WR: assert property (cmd && !we_n && !last_wr |-> gap + 1 >= half + 2)
		else $error("read to write turnaround too short");
	AST_WR2RD: assert property (cmd && we_n && last_wr |->
		gap + 1 >= int'(mode_cl) - 1 + half + TWTR_CK)
		else $error("write to read turnaround too short");
	AST_RD_LAT: assert property ($fell(dev_dqs_oe_n) && rd_exp - rd_got == half |->
		s_rd >= (rl - 1) * 8 - 1 && s_rd <= (rl - 1) * 8 + 6)
		else $error("read preamble at wrong latency");
	AST_WR_LAT: assert property ($fell(ctl_dqs_oe_n) && wr_exp - wr_got == half |->
		s_wr >= (rl - 2) * 8 - 1 && s_wr <= (rl - 2) * 8 + 2)
		else $error("write preamble at wrong latency");
	AST_RD_PRE: assert property ($fell(dev_dqs_oe_n) |-> (dev_dq_oe_n && !dev_dqs_o)[*6])
		else $error("read preamble not low before data");
	AST_RD_ALIGN: assert property (!dev_dq_oe_n && $changed(dev_dqs_o) |-> $stable(dev_dq_o))
		else $error("read data moved on strobe edge");
	AST_RD_BEATS: assert property ($rose(dev_dqs_oe_n) |-> rd_got == rd_exp)
		else $error("read strobe beat count wrong");
	AST_WR_BEATS: assert property ($rose(ctl_dqs_oe_n) |-> wr_got == wr_exp)
		else $error("write strobe beat count wrong");
endmodule // ddrb_assertions

/* File: ddr2_read_write_burst_access_tb_top.sv */
`timescale 1ns/100ps
module ddr2_read_write_burst_access_tb_top
	import ddrb_pkg::*;
;
	logic pclk;
	logic presetn;
	logic [7:0] paddr;
	logic psel, penable, pwrite, pready, pslverr, e;
	logic [31:0] pwdata, prdata, q;
	logic [2:0] mode_burst, mode_cl, mode_al;
	logic mode_interleave;
	int fails = 0;
	int samples_checked = 0;
	int seed = 18231;
	int model [64];

	ddrb_if link_if();
	ddrb_ctrl i_ddrb_ctrl(.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .link(link_if.ctrl));
	ddrb_device i_ddrb_device(.pclk(pclk), .presetn(presetn), .link(link_if.dev),
		.mode_burst(mode_burst), .mode_interleave(mode_interleave), .mode_cl(mode_cl),
		.mode_al(mode_al));
	ddrb_assertions i_ddrb_assertions(.pclk(pclk), .presetn(presetn), .mode_burst(mode_burst),
		.mode_cl(mode_cl), .mode_al(mode_al), .ck(link_if.ck), .cs_n(link_if.cs_n),
		.ras_n(link_if.ras_n), .cas_n(link_if.cas_n), .we_n(link_if.we_n), .addr(link_if.addr),
		.ba(link_if.ba), .ctl_dqs_o(link_if.ctl_dqs_o), .ctl_dqs_oe_n(link_if.ctl_dqs_oe_n),
		.dev_dq_o(link_if.dev_dq_o), .dev_dq_oe_n(link_if.dev_dq_oe_n),
		.dev_dqs_o(link_if.dev_dqs_o), .dev_dqs_oe_n(link_if.dev_dqs_oe_n));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task give_verdict;
		if (fails == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// ----------------------------------------
	// APB master, entered just after a rising edge
	// ----------------------------------------
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 1000);
		if (n >= 1000) fails++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wait_idle;
		int n;
		n = 0;
		do begin
			apb(REG_STATUS, 1'b0, 32'h0);
			n++;
		end while (q[0] !== 1'b0 && n < 500);
		if (n >= 500) fails++;
	endtask

	// Column of beat k from start st
	function automatic int col(int st, int k, bit il);
		return (((st ^ k) >> 2) & 1) * 4 + ((il ? (st ^ k) : (st + k)) & 3);
	endfunction

	initial begin
		#200000;
		fails++;
		give_verdict;
	end

	initial begin
		logic [63:0] w, x;
		int bl, il, cl, al, c, b, rc;
		presetn = 1'b0;
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
		mode_burst = BL_CODE_4;
		mode_interleave = 1'b0;
		mode_cl = 3'h3;
		mode_al = 3'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(REG_CFG, 1'b0, 32'h0);
		chk_word(q, CFG_RESET);
		apb(8'h1c, 1'b0, 32'h0);
		chk_word({q[31:1], e}, 32'h1);
		for (int i = 0; i < 8; i++) begin
			bl = i[0] ? 8 : 4;
			il = i >> 1 & 1;
			cl = 3 + (($random(seed) & 255) % 5);
			al = ($random(seed) & 255) % 7;
			c = $random(seed) & 1023;
			b = $random(seed) & 6;
			rc = (bl == 8) ? ($random(seed) & 7) : ((c & 4) | ($random(seed) & 3));
			w = {$random(seed), $random(seed)};
			mode_burst <= (bl == 8) ? BL_CODE_8 : BL_CODE_4;
			mode_interleave <= il[0];
			mode_cl <= cl[2:0];
			mode_al <= al[2:0];
			apb(REG_CFG, 1'b1, (al << CFG_AL_LSB) | (cl << CFG_CL_LSB) | (il << CFG_INTLV_BIT)
				| ((al > 0) << CFG_EARLY_BIT) | ((bl == 8) ? BL_CODE_8 : BL_CODE_4));
			apb(REG_WDATA_LO, 1'b1, w[31:0]);
			apb(REG_WDATA_HI, 1'b1, w[63:32]);
			apb(REG_WDATA_HI, 1'b0, 32'h0);
			chk_word(q, w[63:32]);
			for (int j = 0; j < 2; j++) begin
				apb(REG_CMD, 1'b1, 32'h10000 | ((b ^ j) << CMD_BA_LSB) | c);
				for (int k = 0; k < bl; k++)
					model[((b ^ j) << 3) + col(c, k, il)] = int'(w[8 * k +: 8]);
			end
			for (int j = 0; j < 2; j++) apb(REG_CMD, 1'b1, ((b ^ j) << CMD_BA_LSB) | rc);
			wait_idle;
			apb(REG_STATUS, 1'b0, 32'h0);
			chk_word({29'h0, q[2:0]}, 32'h6);
			x = 64'h0;
			for (int k = 0; k < bl; k++)
				x[8 * k +: 8] = 8'(model[((b ^ 1) << 3) + col(rc, k, il)]);
			apb(REG_RDATA_LO, 1'b0, 32'h0);
			chk_word(q, x[31:0]);
			apb(REG_RDATA_HI, 1'b0, 32'h0);
			if (bl == 8) chk_word(q, x[63:32]);
			apb(REG_STATUS, 1'b0, 32'h0);
			chk_word({31'h0, q[2]}, 32'h0);
		end
		give_verdict;
	end
endmodule // ddr2_read_write_burst_access_tb_top
